// *** rtl/tbd_top.sv ***
/*
 * Time base tick generator and buzzer square-wave divider with register port.
 * Assumes one clock (fc) and a simple one-cycle strobe register master.
 */
// Overview of operation
// - Tick event on first and every later falling edge of selected tap after enable.
// - Enabling does not clear the prescaler; first tick may come early.
// - Three-bit tick rate picks one of eight taps; higher code is faster.
// - Half-rate option halves every tick and buzzer rate.
// - Control register: rate select bits 2..0, tick enable bit 3.
// - Enabled buzzer drives about 50% duty square wave on active-low pin.
`timescale 1ns/1ps
module tbd_top (
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	input  wire logic [tbd_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [tbd_pkg::DATA_W-1:0] wr_data_in,
	input  wire logic                      wr_en_in,
	input  wire logic                      rd_en_in,
	output logic      [tbd_pkg::DATA_W-1:0] rd_data_out,
	output logic                           irq_out,
	output logic                           buzzer_out_n_out
);
	import tbd_pkg::*;

	tbd_state_s s_q;
	tbd_state_s s_d;

	function automatic logic [TAP_W-1:0] tick_tap(input logic [2:0] sel, input logic half);
		logic [TAP_W-1:0] t;
		case (sel)
			3'h0: t = TICK_TAP0;
			3'h1: t = TICK_TAP1;
			3'h2: t = TICK_TAP2;
			3'h3: t = TICK_TAP3;
			3'h4: t = TICK_TAP4;
			3'h5: t = TICK_TAP5;
			3'h6: t = TICK_TAP6;
			default: t = TICK_TAP7;
		endcase
		return t + TAP_W'(half);
	endfunction : tick_tap

	function automatic logic [TAP_W-1:0] buz_tap(input logic [1:0] sel, input logic half);
		logic [TAP_W-1:0] t;
		case (sel)
			2'h0: t = BUZ_TAP0;
			2'h1: t = BUZ_TAP1;
			2'h2: t = BUZ_TAP2;
			default: t = BUZ_TAP3;
		endcase
		return t + TAP_W'(half);
	endfunction : buz_tap

	logic [TAP_W-1:0] t_tap;
	logic [TAP_W-1:0] b_tap;
	logic             tick_fall;
	logic             wr_ctrl;
	logic             wr_cfg;
	logic             wr_stat;
	logic             wr_mask;

	always_comb begin
		s_d = s_q;
		wr_ctrl = wr_en_in && (addr_in == OFS_TICK_CTRL);
		wr_cfg  = wr_en_in && (addr_in == OFS_CONFIG);
		wr_stat = wr_en_in && (addr_in == OFS_STATUS);
		wr_mask = wr_en_in && (addr_in == OFS_MASK);

		// Never cleared by software, so taps stay phase-locked to reset
		s_d.div = s_q.div + DIV_W'(1);

		t_tap = tick_tap(s_q.ctrl[TICK_SEL_LSB +: 3], s_q.half);
		b_tap = buz_tap(s_q.ctrl[BUZ_SEL_LSB +: 2], s_q.half);
		// Edge taken from current and next count, so a same-write rate change cannot fake a fall
		tick_fall = s_q.ctrl[TICK_EN_BIT] && s_q.div[t_tap] && !s_d.div[t_tap];

		if (wr_ctrl) begin
			// Bit 4 is held at zero whatever is written
			s_d.ctrl = wr_data_in & CTRL_WR_MASK;
		end
		if (wr_cfg) begin
			s_d.half = wr_data_in[HALF_BIT];
		end
		if (wr_mask) begin
			s_d.mask = wr_data_in[TICK_EV_BIT];
		end
		if (wr_stat && wr_data_in[TICK_EV_BIT]) begin
			s_d.status = 1'b0;
		end
		// Set beats a simultaneous clear
		if (tick_fall) begin
			s_d.status = 1'b1;
		end
		s_d.irq = s_d.status && s_d.mask;

		// Idle level high: inactive on the active-low pin
		s_d.buz_n = s_q.ctrl[BUZ_EN_BIT] ? s_q.div[b_tap] : 1'b1;

		s_d.rdata = '0;
		if (rd_en_in) begin
			case (addr_in)
				OFS_TICK_CTRL: s_d.rdata = s_q.ctrl;
				OFS_CONFIG:    s_d.rdata = {7'h00, s_q.half};
				OFS_STATUS:    s_d.rdata = {7'h00, s_q.status};
				OFS_MASK:      s_d.rdata = {7'h00, s_q.mask};
				default:       s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q.div    <= DIV_RST;
			s_q.ctrl   <= CTRL_RST;
			s_q.half   <= HALF_RST;
			s_q.status <= STATUS_RST;
			s_q.mask   <= MASK_RST;
			s_q.rdata  <= 8'h00;
			s_q.irq    <= 1'b0;
			s_q.buz_n  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_out      = s_q.rdata;
	assign irq_out          = s_q.irq;
	assign buzzer_out_n_out = s_q.buz_n;
endmodule : tbd_top

// *** inc/tbd_pkg.sv ***
/*
 * Package for the time base and buzzer divider: register offsets, field positions,
 * reset values and prescaler tap positions.
 * Assumes the prescaler is clocked directly by the core clock, treated as fc.
 */
package tbd_pkg;
	localparam int unsigned ADDR_W       = 4;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned DIV_W        = 24;
	localparam int unsigned TAP_W        = 5;

	localparam logic [3:0] OFS_TICK_CTRL = 4'h0;
	localparam logic [3:0] OFS_CONFIG    = 4'h1;
	localparam logic [3:0] OFS_STATUS    = 4'h2;
	localparam logic [3:0] OFS_MASK      = 4'h3;

	localparam int unsigned TICK_SEL_LSB = 0;
	localparam int unsigned TICK_EN_BIT  = 3;
	localparam int unsigned RSVD_BIT     = 4;
	localparam int unsigned BUZ_SEL_LSB  = 5;
	localparam int unsigned BUZ_EN_BIT   = 7;
	localparam int unsigned HALF_BIT     = 0;
	localparam int unsigned TICK_EV_BIT  = 0;

	localparam logic [7:0] CTRL_RST      = 8'h00;
	localparam logic [7:0] CTRL_WR_MASK  = 8'hef;
	localparam logic       HALF_RST      = 1'b0;
	localparam logic       STATUS_RST    = 1'b0;
	localparam logic       MASK_RST      = 1'b0;
	localparam logic [23:0] DIV_RST      = 24'h000000;

	// Divider bit whose falling edge ends one period of fc/2^(bit+1)
	localparam logic [4:0] TICK_TAP0     = 5'h16;
	localparam logic [4:0] TICK_TAP1     = 5'h14;
	localparam logic [4:0] TICK_TAP2     = 5'h0f;
	localparam logic [4:0] TICK_TAP3     = 5'h0d;
	localparam logic [4:0] TICK_TAP4     = 5'h0c;
	localparam logic [4:0] TICK_TAP5     = 5'h0b;
	localparam logic [4:0] TICK_TAP6     = 5'h0a;
	localparam logic [4:0] TICK_TAP7     = 5'h08;
	localparam logic [4:0] BUZ_TAP0      = 5'h0c;
	localparam logic [4:0] BUZ_TAP1      = 5'h0b;
	localparam logic [4:0] BUZ_TAP2      = 5'h0a;
	localparam logic [4:0] BUZ_TAP3      = 5'h09;

	typedef struct packed {
		logic [23:0] div;
		logic [7:0]  ctrl;
		logic        half;
		logic        status;
		logic        mask;
		logic [7:0]  rdata;
		logic        irq;
		logic        buz_n;
	} tbd_state_s;
endpackage : tbd_pkg

// *** tb/tbd_chk_sva.sv ***
/* Port checker for tbd_top with its own divider copy; assumes the bind below. */
`timescale 1ns/1ps
module tbd_chk (input wire logic ref_clk_in, rst_in, wr_en_in, rd_en_in, irq_out, buzzer_out_n_out,
	input wire logic [3:0] addr_in, input wire logic [7:0] wr_data_in, rd_data_out);
	import tbd_pkg::*;
	localparam logic [4:0] TP [8] = '{5'h16, 5'h14, 5'h0f, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h08};
	logic [23:0] div_q;
	logic [7:0] ctrl_q;
	logic [1:0] cfg_q; // Mask, half rate
	wire [4:0] tk = TP[ctrl_q[2:0]] + 5'(cfg_q[0]);
	wire [4:0] bk = 5'h0c - 5'(ctrl_q[6:5]) + 5'(cfg_q[0]);
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			{div_q, ctrl_q, cfg_q} <= '0;
		end else begin
			div_q <= div_q + 24'h1;
			if (wr_en_in && addr_in == 4'h0) ctrl_q <= wr_data_in & 8'hef;
			if (wr_en_in && addr_in == 4'h1) cfg_q[0] <= wr_data_in[0];
			if (wr_en_in && addr_in == 4'h3) cfg_q[1] <= wr_data_in[0];
		end
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	buz_off_a: assert property (!ctrl_q[7] |=> buzzer_out_n_out) else $error("pin low");
	buz_tap_a: assert property (ctrl_q[7] |=> buzzer_out_n_out == $past(div_q[bk])) else $error("pin tap");
	tick_edge_a: assert property ($rose(irq_out) && cfg_q[1] && $past(cfg_q[1]) && $past(cfg_q[1], 2)
		|-> $past(ctrl_q[3]) && $past(div_q[tk]) && !div_q[$past(tk)]) else $error("tick edge");
	irq_mask_a: assert property (!cfg_q[1] ##1 !cfg_q[1] |-> !irq_out) else $error("irq masked");
	irq_keep_a: assert property (irq_out && !wr_en_in |=> irq_out) else $error("irq lost");
	rd_ctrl_a: assert property (rd_en_in && addr_in == 4'h0 |=> rd_data_out == $past(ctrl_q)) else $error("ctrl");
	rd_mask_a: assert property (rd_en_in && addr_in == 4'h3 |=> rd_data_out == 8'($past(cfg_q[1]))) else $error("mask");
	rd_zero_a: assert property (!(rd_en_in && addr_in < 4'h4) |=> rd_data_out == 8'h00) else $error("rd zero");
	cover property ($rose(irq_out));
	cover property ($fell(buzzer_out_n_out));
	cover property (cfg_q[0] && ctrl_q[7]);
endmodule : tbd_chk
bind tbd_top tbd_chk i_chk (.ref_clk_in, .rst_in, .wr_en_in, .rd_en_in, .irq_out, .buzzer_out_n_out, .addr_in,
	.wr_data_in, .rd_data_out);

// *** tb/tbd_buzzer.sv ***
/* Buzzer model: cycles between falling pin edges; assumes core-clock sampling. */
`timescale 1ns/1ps
module tbd_buzzer (input wire logic clk_in, input wire logic pin_n_in, output int period_out);
	int cnt = 0;
	logic last = 1'b1;
	always @(posedge clk_in) begin
		cnt <= (last && !pin_n_in) ? 1 : cnt + 1;
		if (last && !pin_n_in) period_out <= cnt;
		last <= pin_n_in;
	end
endmodule : tbd_buzzer

// *** tb/testbench.sv ***
/* Bench for tbd_top: tick and buzzer rates; assumes tbd_buzzer on the pin. */
`timescale 1ns/1ps
module testbench;
	import tbd_pkg::*;
	logic clk = 0, rst = 1, we = 0, re = 0, irq, buz;
	logic [3:0] a = 4'h0;
	logic [7:0] d = 8'h00, q;
	int per, t0, cyc = 0, n_fail = 0, samples_checked = 0;
	tbd_top i_dut (.ref_clk_in(clk), .rst_in(rst), .addr_in(a), .wr_data_in(d), .wr_en_in(we), .rd_en_in(re),
		.rd_data_out(q), .irq_out(irq), .buzzer_out_n_out(buz));
	tbd_buzzer i_buz (.clk_in(clk), .pin_n_in(buz), .period_out(per));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %s exp %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [3:0] ad, input logic [7:0] v);
		{we, a, d} <= {1'b1, ad, v};
		@(posedge clk);
		we <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] ad, input logic [7:0] e);
		{re, a} <= {1'b1, ad};
		@(posedge clk);
		re <= 1'b0;
		#1 chk("rd_data", q, e);
		@(posedge clk);
	endtask : rd
	task automatic wait_irq();
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_irq
	task automatic tick_rate(input logic h);
		wr(OFS_CONFIG, {7'h00, h});
		wr(OFS_MASK, 8'h01);
		wr(OFS_TICK_CTRL, 8'h0f);
		rd(OFS_TICK_CTRL, 8'h0f);
		wait_irq();
		t0 = cyc;
		wr(OFS_STATUS, 8'h01);
		wait_irq();
		chk("tick", cyc - t0, 512 << h);
		wr(OFS_TICK_CTRL, 8'h07);
		wr(OFS_MASK, 8'h00);
		#1 chk("irq", irq, 1'b0);
		rd(OFS_STATUS, 8'h01);
		wr(OFS_STATUS, 8'h01);
		rd(OFS_STATUS, 8'h00);
	endtask : tick_rate
	task automatic buzz(input logic [1:0] c, input logic h);
		wr(OFS_CONFIG, {7'h00, h});
		wr(OFS_TICK_CTRL, {1'b1, c, 5'h00});
		repeat ((16400 >> c) << h) @(posedge clk);
		chk("buzz", per, (8192 >> c) << h);
		wr(OFS_TICK_CTRL, 8'h00);
	endtask : buzz
	task automatic finish_test();
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pin", buz, 1'b1);
		rd(4'h5, 8'h00);
		tick_rate(1'b0);
		tick_rate(1'b1);
		for (int c = 0; c < 4; c++) buzz(2'(c), 1'b0);
		buzz(2'h0, 1'b1);
		finish_test();
	end
endmodule : testbench
